// File: hw/pcr_pkg.sv
package pcr_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int FRAME_BITS     = 32;
	localparam int DATA_BITS      = 24;
	localparam int ADDR_BITS      = 5;
	localparam int CHIP_BITS      = 3;
	localparam int FRAME_CNT_W    = 6;
	localparam logic [2:0] CHIP_ADDR_OWN = 3'h0;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [4:0] REG_ID_RDADDR = 5'h00;
	localparam logic [4:0] REG_PWR_EN    = 5'h01;
	localparam logic [4:0] REG_REF_DIV   = 5'h02;
	localparam logic [4:0] REG_INT_DIV   = 5'h03;
	localparam int         REG_COUNT     = 4;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int RDADDR_MSB      = 4;
	localparam int SOFT_RST_BIT    = 5;
	localparam int PWR_SEL_PIN_BIT = 0;
	localparam int PWR_SPI_EN_BIT  = 1;
	localparam int KEEP_BIAS_BIT   = 2;
	localparam int KEEP_PD_BIT     = 3;
	localparam int KEEP_CP_BIT     = 4;
	localparam int KEEP_REFBUF_BIT = 5;
	localparam int KEEP_DIVBUF_BIT = 6;
	localparam int KEEP_DRV_BIT    = 7;
	localparam int PWR_W           = 10;
	localparam int REF_DIV_W       = 14;
	localparam int INT_DIV_W       = 19;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [9:0]  PWR_EN_RST  = 10'h003;
	localparam logic [13:0] REF_DIV_RST = 14'h0001;
	localparam logic [18:0] INT_DIV_RST = 19'h00019;
	localparam logic [4:0]  RDADDR_RST  = 5'h00;
	// Arbitrary neutral identifier value
	localparam logic [23:0] DEVICE_ID_DEFAULT = 24'h5A0001;

	// ****************************************
	// Host-side legal ranges
	// ****************************************
	localparam logic [13:0] REF_DIV_MIN      = 14'h0001;
	localparam logic [18:0] INT_DIV_FRAC_MIN = 19'h00014;
	localparam logic [18:0] INT_DIV_FRAC_MAX = 19'h7FFFC;
	localparam logic [18:0] INT_DIV_INT_MIN  = 19'h00010;

	typedef enum logic [1:0] {
		LNK_IDLE  = 2'b00,
		LNK_SHIFT = 2'b01,
		LNK_DONE  = 2'b10
	} pcr_link_state_type;

endpackage

// File: hw/pcr_sync.sv
module pcr_sync
	import pcr_pkg::*;
(
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_b_in,
	// Level crossing
	input  wire logic d_in,
	output logic      q_out
);

	logic meta_r;

	// Two stages; first stage read only by second
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_r <= 1'b0;
			q_out  <= 1'b0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end

endmodule

// File: hw/pcr_toggle_sync.sv
module pcr_toggle_sync
	import pcr_pkg::*;
(
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_b_in,
	// Toggle from the other domain
	input  wire logic tog_in,
	output logic      pulse_out
);

	logic q_w;
	logic last_r;

	pcr_sync u_sync (
		.mclk_in  (mclk_in),
		.rst_b_in (rst_b_in),
		.d_in     (tog_in),
		.q_out    (q_w)
	);

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			last_r <= 1'b0;
		end else begin
			last_r <= q_w;
		end
	end

	assign pulse_out = q_w ^ last_r;

endmodule

// File: hw/pcr_reg_bank.sv
module pcr_reg_bank
	import pcr_pkg::*;
#(
	parameter logic [23:0] DEVICE_ID = DEVICE_ID_DEFAULT
)
(
	// System clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 rst_b_in,
	// Serial link
	input  wire logic                 sclk_in,
	input  wire logic                 sdi_in,
	input  wire logic                 serial_latch_enable_in,
	// Shared pin
	output logic                      lock_or_serial_out_pin_out,
	output logic                      lock_or_serial_out_oe_b_out,
	input  wire logic                 lock_detect_in,
	// Power control
	input  wire logic                 chip_enable_pin_in,
	output logic                      chip_enabled_out,
	output logic                      bias_on_out,
	output logic                      phase_det_on_out,
	output logic                      charge_pump_on_out,
	output logic                      ref_buf_on_out,
	output logic                      div_buf_on_out,
	output logic                      pin_drv_on_out,
	// Divider settings and soft reset
	output logic [REF_DIV_W-1:0]      ref_div_out,
	output logic [INT_DIV_W-1:0]      int_div_out,
	output logic                      soft_reset_out
);

	// ****************************************
	// Link domain: shifter and read-back
	// ****************************************
	logic [FRAME_BITS-1:0]   shift_r;
	logic [FRAME_CNT_W-1:0]  bit_cnt_r;
	logic [DATA_BITS-1:0]    rd_shift_r;
	logic                    rd_active_r;
	logic [FRAME_BITS-1:0]   frame_hold_r;
	logic                    frame_tog_r;
	logic [DATA_BITS-1:0]    rd_word_w;
	logic                    le_sync_w;
	logic                    le_rise_w;
	logic                    le_last_r;
	logic                    frame_pulse_w;
	logic                    rd_active_m_w;

	function automatic logic [DATA_BITS-1:0] reg_read(
		input logic [4:0]            addr,
		input logic [PWR_W-1:0]      pwr,
		input logic [REF_DIV_W-1:0]  rdiv,
		input logic [INT_DIV_W-1:0]  idiv
	);
		case (addr)
			REG_ID_RDADDR: reg_read = DEVICE_ID;
			REG_PWR_EN:    reg_read = {{(DATA_BITS-PWR_W){1'b0}}, pwr};
			REG_REF_DIV:   reg_read = {{(DATA_BITS-REF_DIV_W){1'b0}}, rdiv};
			REG_INT_DIV:   reg_read = {{(DATA_BITS-INT_DIV_W){1'b0}}, idiv};
			default:       reg_read = '0;
		endcase
	endfunction

	// Shift register samples SDI on every rising edge
	always_ff @(posedge sclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shift_r <= '0;
		end else begin
			shift_r <= {shift_r[FRAME_BITS-2:0], sdi_in};
		end
	end

	// Bit count restarts after each latch; counted in link domain
	always_ff @(posedge sclk_in or posedge serial_latch_enable_in
		or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bit_cnt_r <= '0;
		end else if (serial_latch_enable_in) begin
			bit_cnt_r <= '0;
		end else if (bit_cnt_r != FRAME_CNT_W'(FRAME_BITS)) begin
			bit_cnt_r <= bit_cnt_r + 6'h01;
		end
	end

	// Read data shifts out MSB first, one bit per rising edge
	always_ff @(posedge sclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_shift_r <= '0;
		end else if (bit_cnt_r == '0) begin
			rd_shift_r <= rd_word_w;
		end else begin
			rd_shift_r <= {rd_shift_r[DATA_BITS-2:0], 1'b0};
		end
	end

	// Read-back starts without latch; only latch rise ends it
	always_ff @(posedge sclk_in or posedge serial_latch_enable_in
		or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_active_r <= 1'b0;
		end else if (serial_latch_enable_in) begin
			rd_active_r <= 1'b0;
		end else begin
			rd_active_r <= 1'b1;
		end
	end

	// Frame captured at latch rise, handed over by toggle
	always_ff @(posedge serial_latch_enable_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			frame_hold_r <= '0;
			frame_tog_r  <= 1'b0;
		end else begin
			frame_hold_r <= shift_r;
			frame_tog_r  <= ~frame_tog_r;
		end
	end

	// ****************************************
	// System domain: crossings
	// ****************************************
	pcr_sync u_le_sync (
		.mclk_in  (mclk_in),
		.rst_b_in (rst_b_in),
		.d_in     (serial_latch_enable_in),
		.q_out    (le_sync_w)
	);

	pcr_sync u_rd_sync (
		.mclk_in  (mclk_in),
		.rst_b_in (rst_b_in),
		.d_in     (rd_active_r),
		.q_out    (rd_active_m_w)
	);

	pcr_toggle_sync u_frame_sync (
		.mclk_in   (mclk_in),
		.rst_b_in  (rst_b_in),
		.tog_in    (frame_tog_r),
		.pulse_out (frame_pulse_w)
	);

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			le_last_r <= 1'b0;
		end else begin
			le_last_r <= le_sync_w;
		end
	end
	assign le_rise_w = le_sync_w & ~le_last_r;

	// ****************************************
	// System domain: register file
	// ****************************************
	logic [PWR_W-1:0]     pwr_r;
	logic [REF_DIV_W-1:0] rdiv_r;
	logic [INT_DIV_W-1:0] idiv_r;
	logic [4:0]           rd_addr_r;
	logic                 wr_ok_w;
	logic [4:0]           wr_addr_w;
	logic [DATA_BITS-1:0] wr_data_w;
	logic [DATA_BITS-1:0] rd_word_r;

	assign wr_data_w = frame_hold_r[FRAME_BITS-1 -: DATA_BITS];
	assign wr_addr_w = frame_hold_r[CHIP_BITS +: ADDR_BITS];
	// Frame hold is stable long after toggle reaches this side
	assign wr_ok_w   = frame_pulse_w &&
		(frame_hold_r[CHIP_BITS-1:0] == CHIP_ADDR_OWN);

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pwr_r          <= PWR_EN_RST;
			rdiv_r         <= REF_DIV_RST;
			idiv_r         <= INT_DIV_RST;
			rd_addr_r      <= RDADDR_RST;
			soft_reset_out <= 1'b0;
		end else if (wr_ok_w && wr_addr_w == REG_ID_RDADDR
			&& wr_data_w[SOFT_RST_BIT]) begin
			pwr_r          <= PWR_EN_RST;
			rdiv_r         <= REF_DIV_RST;
			idiv_r         <= INT_DIV_RST;
			rd_addr_r      <= RDADDR_RST;
			soft_reset_out <= 1'b1;
		end else begin
			soft_reset_out <= 1'b0;
			if (wr_ok_w) begin
				case (wr_addr_w)
					REG_ID_RDADDR: rd_addr_r <= wr_data_w[RDADDR_MSB:0];
					REG_PWR_EN:    pwr_r  <= wr_data_w[PWR_W-1:0];
					REG_REF_DIV:   rdiv_r <= wr_data_w[REF_DIV_W-1:0];
					REG_INT_DIV:   idiv_r <= wr_data_w[INT_DIV_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// Read word registered here, sampled by link only at frame start
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_word_r <= '0;
		end else begin
			rd_word_r <= reg_read(rd_addr_r, pwr_r, rdiv_r, idiv_r);
		end
	end
	assign rd_word_w = rd_word_r;

	// ****************************************
	// Power control
	// ****************************************
	logic pin_en_w;

	pcr_sync u_en_sync (
		.mclk_in  (mclk_in),
		.rst_b_in (rst_b_in),
		.d_in     (chip_enable_pin_in),
		.q_out    (pin_en_w)
	);

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			chip_enabled_out <= 1'b0;
		end else if (pwr_r[PWR_SEL_PIN_BIT]) begin
			chip_enabled_out <= pin_en_w;
		end else begin
			chip_enabled_out <= pwr_r[PWR_SPI_EN_BIT];
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bias_on_out        <= 1'b0;
			phase_det_on_out   <= 1'b0;
			charge_pump_on_out <= 1'b0;
			ref_buf_on_out     <= 1'b0;
			div_buf_on_out     <= 1'b0;
			pin_drv_on_out     <= 1'b0;
		end else begin
			bias_on_out        <= chip_enabled_out | pwr_r[KEEP_BIAS_BIT];
			phase_det_on_out   <= chip_enabled_out | pwr_r[KEEP_PD_BIT];
			charge_pump_on_out <= chip_enabled_out | pwr_r[KEEP_CP_BIT];
			ref_buf_on_out     <= chip_enabled_out | pwr_r[KEEP_REFBUF_BIT];
			div_buf_on_out     <= chip_enabled_out | pwr_r[KEEP_DIVBUF_BIT];
			pin_drv_on_out     <= chip_enabled_out | pwr_r[KEEP_DRV_BIT];
		end
	end

	assign ref_div_out = rdiv_r;
	assign int_div_out = idiv_r;

	// ****************************************
	// Shared pin mux
	// ****************************************
	logic lock_sync_w;
	pcr_sync u_lock_sync (
		.mclk_in  (mclk_in),
		.rst_b_in (rst_b_in),
		.d_in     (lock_detect_in),
		.q_out    (lock_sync_w)
	);

	// Read data straight from link flop so it follows serial clock edges
	assign lock_or_serial_out_pin_out = rd_active_r ?
		rd_shift_r[DATA_BITS-1] : lock_sync_w;
	assign lock_or_serial_out_oe_b_out = 1'b0;

	// ****************************************
	// Checks
	// ****************************************
	a_id_fixed: assert property (@(posedge mclk_in)
		disable iff (!rst_b_in)
		rd_addr_r == REG_ID_RDADDR |=> rd_word_r == DEVICE_ID)
		else $error("identifier read wrong");
	a_rdaddr_store: assert property (@(posedge mclk_in)
		disable iff (!rst_b_in) wr_ok_w && wr_addr_w == REG_ID_RDADDR
		&& !wr_data_w[SOFT_RST_BIT]
		|=> rd_addr_r == $past(wr_data_w[RDADDR_MSB:0]))
		else $error("read address not stored");
	a_soft_rst: assert property (@(posedge mclk_in)
		disable iff (!rst_b_in) soft_reset_out |-> pwr_r == PWR_EN_RST
		&& rdiv_r == REF_DIV_RST && idiv_r == INT_DIV_RST)
		else $error("soft reset left registers");
	a_pin_follow: assert property (@(posedge mclk_in)
		disable iff (!rst_b_in) pwr_r[PWR_SEL_PIN_BIT]
		|=> chip_enabled_out == $past(pin_en_w))
		else $error("pin enable not followed");
	a_spi_enable: assert property (@(posedge mclk_in)
		disable iff (!rst_b_in) !pwr_r[PWR_SEL_PIN_BIT]
		|=> chip_enabled_out == $past(pwr_r[PWR_SPI_EN_BIT]))
		else $error("register enable not followed");
	a_keep_bias: assert property (@(posedge mclk_in)
		disable iff (!rst_b_in) pwr_r[KEEP_BIAS_BIT] |=> bias_on_out)
		else $error("bias override ignored");
	a_keep_driver: assert property (@(posedge mclk_in)
		disable iff (!rst_b_in) pwr_r[KEEP_DRV_BIT] |=> pin_drv_on_out)
		else $error("driver override ignored");
	a_reserved_pwr: assert property (@(posedge mclk_in)
		disable iff (!rst_b_in) soft_reset_out |-> pwr_r[PWR_W-1 -: 2] == 2'h0)
		else $error("reserved bits set");
	a_pin_revert: assert property (@(posedge mclk_in)
		disable iff (!rst_b_in)
		$fell(rd_active_m_w) |-> le_rise_w || $past(le_rise_w))
		else $error("pin reverted without latch");
	a_out_step: assert property (@(posedge sclk_in)
		disable iff (!rst_b_in) bit_cnt_r != '0 && rd_active_r
		|=> rd_shift_r[DATA_BITS-1] == $past(rd_shift_r[DATA_BITS-2]))
		else $error("serial out not advanced");

	c_write: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
		wr_ok_w && wr_addr_w == REG_INT_DIV);
	c_soft_rst: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
		soft_reset_out);
	c_readback: cover property (@(posedge sclk_in) disable iff (!rst_b_in)
		bit_cnt_r == 6'h20 && rd_active_r);

endmodule

// File: verif/pcr_host_model.sv
module pcr_host_model
	import pcr_pkg::*;
(
	// Serial link
	output logic      sclk_out,
	output logic      sdi_out,
	output logic      serial_latch_enable_out,
	// Shared pin
	input  wire logic pin_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****
	// Host frame engine
	// ****
	initial begin
		sclk_out = 1'b0;
		sdi_out = 1'b0;
		serial_latch_enable_out = 1'b0;
	end

	// Clock only inside frames; gap slows the host
	task automatic frame(input logic [23:0] data, input logic [4:0] addr,
		input logic [2:0] chip, input int gap, output logic [23:0] rd);
		logic [31:0] word;
		word = {data, addr, chip};
		rd = '0;
		for (int i = 31; i >= 0; i--) begin
			sdi_out = word[i];
			#(7.5 + gap);
			sclk_out = 1'b1;
			#7.5;
			if (i >= 8)
				rd[i-8] = pin_in;
			sclk_out = 1'b0;
		end
		// Released data line must not hold the old bit
		sdi_out = ~sdi_out;
		#10;
		serial_latch_enable_out = 1'b1;
		#20;
		serial_latch_enable_out = 1'b0;
		#200;
	endtask
endmodule

// File: verif/pcr_reg_bank_test.sv
module pcr_reg_bank_test
	import pcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ****
	// Signals
	// ****
	logic                 mclk_in = 1'b0;
	logic                 rst_b_in;
	logic                 sclk, sdi, latch, pin, oe_b;
	logic                 lock_det, en_pin, sr, sr_seen;
	logic                 chip_en, bias, pd, cp, rbuf, dbuf, drv;
	logic [REF_DIV_W-1:0] ref_div;
	logic [INT_DIV_W-1:0] int_div;
	int                   err_total = 0;
	int                   cmp_count = 0;
	wire logic [6:0]      pwr_seen = {drv, dbuf, rbuf, cp, pd, bias, chip_en};

	always #10 mclk_in = ~mclk_in;

	pcr_reg_bank dut_u (
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .sclk_in(sclk),
		.sdi_in(sdi), .serial_latch_enable_in(latch),
		.lock_or_serial_out_pin_out(pin),
		.lock_or_serial_out_oe_b_out(oe_b), .lock_detect_in(lock_det),
		.chip_enable_pin_in(en_pin), .chip_enabled_out(chip_en),
		.bias_on_out(bias), .phase_det_on_out(pd),
		.charge_pump_on_out(cp), .ref_buf_on_out(rbuf),
		.div_buf_on_out(dbuf), .pin_drv_on_out(drv),
		.ref_div_out(ref_div), .int_div_out(int_div),
		.soft_reset_out(sr)
	);

	pcr_host_model host_u (
		.sclk_out(sclk), .sdi_out(sdi), .serial_latch_enable_out(latch),
		.pin_in(pin)
	);

	always @(posedge mclk_in)
		if (sr === 1'b1)
			sr_seen <= 1'b1;

	// ****
	// Helpers
	// ****
	task automatic chk(input string name, input logic [23:0] seen,
		input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [23:0] d, input logic [4:0] a,
		input logic [2:0] c, output logic [23:0] rd);
		#($urandom_range(1, 9));
		host_u.frame(d, a, c, 20 * $urandom_range(0, 1), rd);
	endtask

	// Select then fetch; second frame rewrites the same select
	task automatic rdreg(input logic [4:0] a, output logic [23:0] v);
		logic [23:0] d;
		wr({19'h0, a}, REG_ID_RDADDR, 3'h0, d);
		wr({19'h0, a}, REG_ID_RDADDR, 3'h0, v);
	endtask

	function automatic logic [6:0] pwr_exp(input logic [9:0] p,
		input logic pin_lv);
		logic en;
		en = p[0] ? pin_lv : p[1];
		return {p[7:2] | {6{en}}, en};
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		wrap_up();
	end

	// ****
	// Tests
	// ****
	initial begin
		logic [23:0] v, d;
		logic [13:0] rv;
		logic [18:0] iv;
		logic [9:0]  p;
		void'($urandom(32'hB2C6));
		rst_b_in = 1'b0;
		lock_det = 1'b0;
		en_pin = 1'b1;
		sr_seen = 1'b0;
		repeat (10) @(posedge mclk_in);
		@(negedge mclk_in) rst_b_in <= 1'b1;
		repeat (6) @(negedge mclk_in);
		chk("ref_div", 24'(ref_div), 24'h000001);
		chk("int_div", 24'(int_div), 24'h000019);
		chk("power", 24'(pwr_seen), 24'(pwr_exp(10'h003, 1'b1)));
		chk("oe_b", 24'(oe_b), 24'h000000);
		rdreg(REG_PWR_EN, v);
		chk("power reg", v, 24'h000003);
		rdreg(REG_ID_RDADDR, v);
		chk("identifier", v, DEVICE_ID_DEFAULT);
		$display("test reset done");

		for (int k = 0; k < 6; k++) begin
			rv = (k == 0) ? 14'h0001 : (k == 1) ? 14'h3FFF :
				14'($urandom_range(1, 16383));
			iv = (k == 0) ? 19'h00010 : (k == 1) ? 19'h7FFFF :
				19'($urandom_range(20, 524284));
			wr(24'(rv), REG_REF_DIV, 3'h0, d);
			wr(24'(iv), REG_INT_DIV, 3'h0, d);
			chk("ref_div", 24'(ref_div), 24'(rv));
			chk("int_div", 24'(int_div), 24'(iv));
			rdreg(REG_REF_DIV, v);
			chk("ref read", v, 24'(rv));
			rdreg(REG_INT_DIV, v);
			chk("int read", v, 24'(iv));
		end
		$display("test dividers done");

		wr(24'h000055, REG_REF_DIV, 3'h4, d);
		chk("foreign chip", 24'(ref_div), 24'(rv));
		wr(24'hFFFFFF, 5'h07, 3'h0, d);
		rdreg(5'h07, v);
		chk("unmapped", v, 24'h000000);
		rdreg(REG_ID_RDADDR, v);
		chk("identifier", v, DEVICE_ID_DEFAULT);
		$display("test refusals done");

		for (int k = 0; k < 8; k++) begin
			p = 10'($urandom);
			p[0] = k[0];
			wr(24'(p), REG_PWR_EN, 3'h0, d);
			for (int b = 0; b < 2; b++) begin
				@(negedge mclk_in) en_pin <= b[0];
				repeat (8) @(negedge mclk_in);
				chk("power", 24'(pwr_seen), 24'(pwr_exp(p, b[0])));
			end
			rdreg(REG_PWR_EN, v);
			chk("power reg", v, 24'(p));
		end
		$display("test power done");

		sr_seen = 1'b0;
		wr(24'h000020, REG_ID_RDADDR, 3'h0, d);
		chk("soft reset", 24'(sr_seen), 24'h000001);
		chk("ref_div", 24'(ref_div), 24'h000001);
		chk("int_div", 24'(int_div), 24'h000019);
		rdreg(REG_PWR_EN, v);
		chk("power reg", v, 24'h000003);
		for (int b = 0; b < 2; b++) begin
			@(negedge mclk_in) lock_det <= b[0];
			repeat (3) @(negedge mclk_in);
			chk("lock pin", 24'(pin), 24'(b));
		end
		$display("test soft reset done");
		wrap_up();
	end
endmodule
